// [hdl/sis_ranker.sv]
/*
 * Ranks one ADC code against up to five ascending thresholds.
 * Assumes the enabled thresholds are programmed in rising order.
 */
`timescale 1ns/10ps
`default_nettype none

module sis_ranker
(
    input wire logic [sis_pkg::ADC_W-1:0] value_i,
    input wire logic [sis_pkg::NUM_THR*sis_pkg::ADC_W-1:0] thr_i,
    input wire logic [sis_pkg::NUM_THR-1:0] mask_i,
    output logic [sis_pkg::RANK_W-1:0] rank_o
);

    // Equality selects the higher code
    function automatic logic [sis_pkg::RANK_W-1:0] count_met(
        input logic [sis_pkg::ADC_W-1:0] v,
        input logic [sis_pkg::NUM_THR*sis_pkg::ADC_W-1:0] t,
        input logic [sis_pkg::NUM_THR-1:0] m
    );
        logic [sis_pkg::RANK_W-1:0] c;
        c = 3'h0;
        for (int k = 0; k < sis_pkg::NUM_THR; k++)
        begin
            if (m[k] && (v >= t[k*sis_pkg::ADC_W +: sis_pkg::ADC_W]))
            begin
                c = c + 3'h1;
            end
        end
        return c;
    endfunction

    always_comb
    begin
        rank_o = count_met(value_i, thr_i, mask_i);
    end

endmodule

`default_nettype wire

// [hdl/sis_status_bank.sv]
/*
 * Switch input status bank: comparator status and the two ADC threshold
 * status words, refreshed per completed sample and read by the host.
 * Assumes one sample report per cycle at most from the sequencer and a
 * read request port from the serial front end; all inputs synchronous.
 */
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Comparator status bit n of inputs 0 to 9 is 1 when the input is above the comparator threshold, else 0.
// - The low ADC status word sits at word offset 6, is read only and resets to zero.
// - The high ADC status word sits at word offset 7, is read only and resets to zero.
// - Inputs 0 to 11 in ADC mode set bit n of the low ADC word when at or above their threshold, else clear it.
// - Inputs 12 to 17 report a code 0, 1 or 2 against thresholds 2A and 2B in bits 13-12 up to 23-22, never 3.
// - The low ADC word only takes results of inputs configured for ADC mode.
// - Inputs 18 to 22 report a code 0 to 3 against 3A, 3B and 3C in bits 1-0 up to 9-8.
// - Input 23 reports a code 0 to 5 in bits 12-10 against five thresholds, and bits 23-13 read zero.
// - The high ADC word only takes results of inputs configured for ADC mode.
// - Comparator status bits only change for inputs in comparator mode.
module sis_status_bank
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire sis_pkg::sis_sample_s sample_i,
    input wire sis_pkg::sis_thresholds_s thr_i,
    input wire sis_pkg::sis_rd_req_s rd_req_i,
    output logic [sis_pkg::REG_W-1:0] rd_data_o,
    output logic rd_valid_o,
    output logic [sis_pkg::REG_W-1:0] comp_status_o,
    output logic [sis_pkg::REG_W-1:0] adc_status_low_o,
    output logic [sis_pkg::REG_W-1:0] adc_status_high_o
);

    logic [sis_pkg::REG_W-1:0] comp_status_r;
    logic [sis_pkg::REG_W-1:0] comp_status_nxt;
    logic [sis_pkg::REG_W-1:0] adc_low_r;
    logic [sis_pkg::REG_W-1:0] adc_low_nxt;
    logic [sis_pkg::REG_W-1:0] adc_high_r;
    logic [sis_pkg::REG_W-1:0] adc_high_nxt;
    logic [sis_pkg::REG_W-1:0] rd_data_r;
    logic [sis_pkg::REG_W-1:0] rd_data_nxt;
    logic rd_valid_r;
    logic rd_valid_nxt;

    logic [sis_pkg::NUM_THR*sis_pkg::ADC_W-1:0] rank_thr;
    logic [sis_pkg::NUM_THR-1:0] rank_mask;
    logic [sis_pkg::RANK_W-1:0] rank;

    logic [4:0] idx;
    logic is_single;
    logic is_three;
    logic is_four;
    logic is_six;
    logic [4:0] pos_three;
    logic [4:0] pos_four;

    function automatic logic in_range(
        input logic [4:0] v,
        input logic [4:0] lo,
        input logic [4:0] hi
    );
        return (v >= lo) && (v <= hi);
    endfunction

    // Bit position of a two-bit code field inside its status word
    function automatic logic [4:0] pair_pos(
        input logic [4:0] v,
        input logic [4:0] first,
        input logic [4:0] base
    );
        logic [4:0] ofs;
        ofs = v - first;
        return base + {ofs[3:0], 1'b0};
    endfunction

    always_comb
    begin
        idx = sample_i.index;
        is_single = (idx <= sis_pkg::SINGLE_LAST_IN);
        is_three = in_range(idx, sis_pkg::THREE_FIRST_IN, sis_pkg::THREE_LAST_IN);
        is_four = in_range(idx, sis_pkg::FOUR_FIRST_IN, sis_pkg::FOUR_LAST_IN);
        is_six = (idx == sis_pkg::SIX_IN);
        pos_three = pair_pos(idx, sis_pkg::THREE_FIRST_IN, 5'(sis_pkg::THREE_BASE_POS));
        pos_four = pair_pos(idx, sis_pkg::FOUR_FIRST_IN, 5'(sis_pkg::FOUR_BASE_POS));
    end

    // Threshold set picked by the input's class
    always_comb
    begin
        rank_thr = '0;
        rank_mask = '0;
        if (is_single)
        begin
            rank_thr = {40'h0000000000, thr_i.single_thr};
            rank_mask = sis_pkg::MASK_SINGLE;
        end
        else if (is_three)
        begin
            rank_thr = {30'h00000000, thr_i.thr_2b, thr_i.thr_2a};
            rank_mask = sis_pkg::MASK_THREE;
        end
        else if (is_four)
        begin
            rank_thr = {20'h00000, thr_i.thr_3c, thr_i.thr_3b, thr_i.thr_3a};
            rank_mask = sis_pkg::MASK_FOUR;
        end
        else
        begin
            rank_thr = {thr_i.ninth_threshold, thr_i.eighth_threshold,
                        thr_i.thr_3c, thr_i.thr_3b, thr_i.thr_3a};
            rank_mask = sis_pkg::MASK_SIX;
        end
    end

    sis_ranker u_ranker
    (
        .value_i(sample_i.adc_code),
        .thr_i(rank_thr),
        .mask_i(rank_mask),
        .rank_o(rank)
    );

    // Comparator word: a sample in ADC mode never reaches it
    always_comb
    begin
        comp_status_nxt = comp_status_r;
        if (sample_i.valid)
        begin
            if (!sample_i.adc_mode && (idx <= sis_pkg::COMP_LAST_IN))
            begin
                comp_status_nxt[idx] = sample_i.comp_above;
            end
        end
    end

    // ADC words: only ADC-mode samples; indices above 23 fall through
    always_comb
    begin
        adc_low_nxt = adc_low_r;
        adc_high_nxt = adc_high_r;
        if (sample_i.valid && sample_i.adc_mode)
        begin
            if (is_single)
            begin
                adc_low_nxt[idx] = rank[0];
            end
            else if (is_three)
            begin
                adc_low_nxt[pos_three +: 2] = rank[1:0];
            end
            else if (is_four)
            begin
                adc_high_nxt[pos_four +: 2] = rank[1:0];
            end
            else if (is_six)
            begin
                adc_high_nxt[sis_pkg::SIX_POS +: 3] = rank;
            end
        end
        // Reserved bits are forced so no stale value can ever show
        adc_high_nxt[23:13] = 11'h000;
    end

    // Reads only copy a word out; stored status is untouched
    always_comb
    begin
        rd_valid_nxt = rd_req_i.en;
        rd_data_nxt = rd_data_r;
        if (rd_req_i.en)
        begin
            case (rd_req_i.addr)
                sis_pkg::COMP_STATUS_OFS: rd_data_nxt = comp_status_r;
                sis_pkg::ADC_LOW_OFS: rd_data_nxt = adc_low_r;
                sis_pkg::ADC_HIGH_OFS: rd_data_nxt = adc_high_r;
                default: rd_data_nxt = 24'h000000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
        begin
            comp_status_r <= sis_pkg::COMP_STATUS_RST;
        end
        else
        begin
            comp_status_r <= comp_status_nxt;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
        begin
            adc_low_r <= sis_pkg::ADC_LOW_RST;
            adc_high_r <= sis_pkg::ADC_HIGH_RST;
        end
        else
        begin
            adc_low_r <= adc_low_nxt;
            adc_high_r <= adc_high_nxt;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
        begin
            rd_data_r <= 24'h000000;
            rd_valid_r <= 1'b0;
        end
        else
        begin
            rd_data_r <= rd_data_nxt;
            rd_valid_r <= rd_valid_nxt;
        end
    end

    always_comb
    begin
        rd_data_o = rd_data_r;
        rd_valid_o = rd_valid_r;
        comp_status_o = comp_status_r;
        adc_status_low_o = adc_low_r;
        adc_status_high_o = adc_high_r;
    end

endmodule

`default_nettype wire

// [include/sis_pkg.sv]
/*
 * Package of the switch input status bank: offsets, field layout, reset
 * values and the packed carriers for samples, thresholds and reads.
 * Assumes one clock domain and a register read port driven by the serial
 * front end of the device.
 */
package sis_pkg;

    localparam int unsigned REG_W = 24;
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned ADC_W = 10;
    localparam int unsigned IDX_W = 5;
    localparam int unsigned RANK_W = 3;
    localparam int unsigned NUM_THR = 5;

    // Word offsets
    localparam logic [5:0] COMP_STATUS_OFS = 6'h05;
    localparam logic [5:0] ADC_LOW_OFS = 6'h06;
    localparam logic [5:0] ADC_HIGH_OFS = 6'h07;

    // Reset values
    localparam logic [23:0] COMP_STATUS_RST = 24'h000000;
    localparam logic [23:0] ADC_LOW_RST = 24'h000000;
    localparam logic [23:0] ADC_HIGH_RST = 24'h000000;

    // Input ranges and field positions
    localparam logic [4:0] COMP_LAST_IN = 5'h09;
    localparam logic [4:0] SINGLE_LAST_IN = 5'h0B;
    localparam logic [4:0] THREE_FIRST_IN = 5'h0C;
    localparam logic [4:0] THREE_LAST_IN = 5'h11;
    localparam logic [4:0] FOUR_FIRST_IN = 5'h12;
    localparam logic [4:0] FOUR_LAST_IN = 5'h16;
    localparam logic [4:0] SIX_IN = 5'h17;
    localparam int unsigned THREE_BASE_POS = 12;
    localparam int unsigned FOUR_BASE_POS = 0;
    localparam int unsigned SIX_POS = 10;

    // Threshold masks for the ranker, one bit per threshold taken part
    localparam logic [4:0] MASK_SINGLE = 5'h01;
    localparam logic [4:0] MASK_THREE = 5'h03;
    localparam logic [4:0] MASK_FOUR = 5'h07;
    localparam logic [4:0] MASK_SIX = 5'h1F;

    typedef logic [ADC_W-1:0] sis_adc_t;

    typedef struct packed {
        logic valid;
        logic [IDX_W-1:0] index;
        logic adc_mode;
        logic comp_above;
        sis_adc_t adc_code;
    } sis_sample_s;

    typedef struct packed {
        sis_adc_t single_thr;
        sis_adc_t thr_2a;
        sis_adc_t thr_2b;
        sis_adc_t thr_3a;
        sis_adc_t thr_3b;
        sis_adc_t thr_3c;
        sis_adc_t eighth_threshold;
        sis_adc_t ninth_threshold;
    } sis_thresholds_s;

    typedef struct packed {
        logic en;
        logic [ADDR_W-1:0] addr;
    } sis_rd_req_s;

endpackage

// [test/sis_host_model.sv]
/* Host side reader of the status words.
   Assumes the one-cycle read answer of the bank. */
`timescale 1ns/10ps
`default_nettype none
module sis_host_model
(
    input wire logic clk_sys_i,
    output var sis_pkg::sis_rd_req_s rd_req_o,
    input wire logic [23:0] rd_data_i,
    input wire logic rd_valid_i
);
    initial rd_req_o = '0;
    task automatic rd(input logic [5:0] a, output logic [23:0] d, output logic ok);
        @(posedge clk_sys_i);
        #1 rd_req_o <= {1'b1, a};
        @(posedge clk_sys_i);
        #1 rd_req_o <= {1'b0, ~a};
        ok = rd_valid_i;
        d = rd_data_i;
    endtask
endmodule
`default_nettype wire

// [test/sis_status_bank_assertions.sv]
/* Port checker of the status bank.
   Assumes it is bound to sis_status_bank in one clock domain. */
`timescale 1ns/10ps
`default_nettype none
module sis_status_bank_chk
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire sis_pkg::sis_sample_s sample_i,
    input wire sis_pkg::sis_thresholds_s thr_i,
    input wire sis_pkg::sis_rd_req_s rd_req_i,
    input wire logic [23:0] rd_data_o,
    input wire logic rd_valid_o,
    input wire logic [23:0] comp_status_o,
    input wire logic [23:0] adc_status_low_o,
    input wire logic [23:0] adc_status_high_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    wire logic cmp_s = sample_i.valid && !sample_i.adc_mode;
    wire logic adc_s = sample_i.valid && sample_i.adc_mode;
    a_read_strobe: assert property (rd_valid_o == $past(rd_req_i.en))
        else $error("read answer timing wrong");
    a_read_low: assert property (rd_req_i.en && rd_req_i.addr == sis_pkg::ADC_LOW_OFS
        |=> rd_data_o == $past(adc_status_low_o)) else $error("low word read wrong");
    a_read_high: assert property (rd_req_i.en && rd_req_i.addr == sis_pkg::ADC_HIGH_OFS
        |=> rd_data_o == $past(adc_status_high_o)) else $error("high word read wrong");
    a_high_rsvd_zero: assert property (adc_status_high_o[23:13] == 11'h000)
        else $error("reserved high bits set");
    a_code_never3: assert property (((adc_status_low_o[23:12]
        & (adc_status_low_o[23:12] >> 1)) & 12'h555) == 12'h000) else $error("code 3 seen");
    a_comp_upper: assert property (comp_status_o[23:10] == 14'h0000)
        else $error("upper comparator bits set");
    a_comp_update: assert property (cmp_s && sample_i.index <= 5'h09
        |=> comp_status_o[$past(sample_i.index)] == $past(sample_i.comp_above))
        else $error("comparator bit not updated");
    a_single_bit: assert property (adc_s && sample_i.index <= 5'h0B
        |=> adc_status_low_o[$past(sample_i.index)]
        == ($past(sample_i.adc_code) >= $past(thr_i.single_thr))) else $error("single bit wrong");
    a_adc_keeps_comp: assert property (adc_s |=> $stable(comp_status_o))
        else $error("adc sample changed comparator word");
    a_comp_keeps_adc: assert property (cmp_s
        |=> $stable({adc_status_low_o, adc_status_high_o})) else $error("adc word changed");
    a_idle_holds: assert property (!sample_i.valid
        |=> $stable({comp_status_o, adc_status_low_o, adc_status_high_o}))
        else $error("status changed without sample");
    c_six_level: cover property (adc_s && sample_i.index == 5'h17);
    c_comp: cover property (cmp_s);
    c_read_high: cover property (rd_req_i.en && rd_req_i.addr == 6'h07);
endmodule
bind sis_status_bank sis_status_bank_chk u_sis_status_bank_chk (.clk_sys_i, .reset_n_i,
    .sample_i, .thr_i, .rd_req_i, .rd_data_o, .rd_valid_o, .comp_status_o, .adc_status_low_o,
    .adc_status_high_o);
`default_nettype wire

// [test/tb_top.sv]
/* Testbench of the status bank.
   Assumes the host model and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    sis_pkg::sis_sample_s sample_i = '0;
    sis_pkg::sis_thresholds_s thr_i = {10'h064, 10'h064, 10'h0C8, 10'h064, 10'h0C8, 10'h12C,
        10'h190, 10'h1F4};
    sis_pkg::sis_rd_req_s rd_req;
    logic [23:0] rd_data, comp_s, low_s, high_s, exp_c, exp_l, exp_h;
    logic rd_valid;
    int n_errors = 0;
    int n_checks = 0;
    int lv[10] = '{99, 100, 199, 200, 299, 300, 399, 400, 499, 500};
    sis_status_bank u_sis_status_bank (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .sample_i(sample_i), .thr_i(thr_i), .rd_req_i(rd_req), .rd_data_o(rd_data),
        .rd_valid_o(rd_valid), .comp_status_o(comp_s), .adc_status_low_o(low_s),
        .adc_status_high_o(high_s));
    sis_host_model u_sis_host_model (.clk_sys_i(clk_sys_i), .rd_req_o(rd_req),
        .rd_data_i(rd_data), .rd_valid_i(rd_valid));
    initial
    begin
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rdchk(input logic [5:0] a, input logic [23:0] exp);
        logic [23:0] d;
        logic ok;
        u_sis_host_model.rd(a, d, ok);
        chk({23'h000000, ok}, 24'h000001);
        chk(d, exp);
    endtask
    task automatic samp(input int i, input logic m, input logic a, input int c);
        int n;
        n = (c >= 100) + (c >= 200) + (c >= 300) + (c >= 400) + (c >= 500);
        @(posedge clk_sys_i);
        #1 sample_i <= {1'b1, 5'(i), m, a, 10'(c)};
        if (!m && i <= 9) exp_c[i] = a;
        else if (m && i <= 11) exp_l[i] = n > 0;
        else if (m && i <= 17) exp_l[12 + 2 * (i - 12) +: 2] = 2'(n > 2 ? 2 : n);
        else if (m && i <= 22) exp_h[2 * (i - 18) +: 2] = 2'(n > 3 ? 3 : n);
        else if (m) exp_h[12:10] = 3'(n);
    endtask
    task automatic check_all(input string name);
        @(posedge clk_sys_i);
        #1 sample_i.valid <= 1'b0;
        rdchk(sis_pkg::COMP_STATUS_OFS, exp_c);
        rdchk(sis_pkg::ADC_LOW_OFS, exp_l);
        rdchk(sis_pkg::ADC_HIGH_OFS, exp_h);
        rdchk(6'h08, 24'h000000);
        chk(high_s, exp_h);
        chk(comp_s, exp_c);
        chk(low_s, exp_l);
        $display("test %s done", name);
    endtask
    task automatic do_reset();
        #1 reset_n_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        #1 reset_n_i <= 1'b1;
        exp_c = 24'h000000;
        exp_l = 24'h000000;
        exp_h = 24'h000000;
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        do_reset();
        check_all("reset");
        for (int k = 0; k < 9; k += 3)
        begin
            for (int i = 0; i < 24; i++)
            begin
                samp(i, 1'b1, 1'b0, lv[(i + k) % 10]);
                samp(i, 1'b0, 1'(i + k), lv[(i + k + 5) % 10]);
            end
            check_all("levels");
        end
        do_reset();
        check_all("second reset");
        finish_test();
    end
endmodule
`default_nettype wire
